// ==== hdl/slew_defs.svh ====
`ifndef SLEW_DEFS_SVH
`define SLEW_DEFS_SVH
`define SLEW_LOCS 64
`define SLEW_ADDR_W 6
`define PARAM_ADDR_W 10
`define PARAM_DATA_W 28
`define TARGET_W 34
`define SLOTS 5
`define SHAPE_MSB 33
`define SHAPE_LSB 32
`define RATE_MSB 31
`define RATE_LSB 28
`define CT_TRIG_BIT 31
`define CT_CNT_MSB 30
`define CT_CNT_LSB 28
`define CT_DATA_MSB 27
`define CT_DATA_LSB 12
`define STEP_CNT_BIAS 6
`define ONE_523 28'h0800000
`define RESET_RATE 4'h5
`define LIN_STEP_UNIT 28'h0002000
`endif

// ==== hdl/slew_pkg.sv ====
package slew_pkg;
    typedef enum logic [1:0] {
        SHAPE_LINEAR = 2'b00,
        SHAPE_CONST_DB = 2'b01,
        SHAPE_RC = 2'b10,
        SHAPE_CONST_TIME = 2'b11
    } shape_e;
    typedef struct packed {
        logic valid;
        logic [9:0] addr;
        logic [33:0] data;
    } slot_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAFELOAD = 2'b01,
        ST_SWEEP = 2'b11
    } state_e;
endpackage

// ==== hdl/slew_ramp_safeload_engine.sv ====
// Contract
// - Target word: shape, rate, 5.23 data.
// - Constant time word: shape, trigger, count, data.
// - Shape codes: linear, dB, RC, time.
// - Linear step scales by rate code.
// - Rate zero fastest, fifteen slowest.
// - Constant dB step from current slew.
// - RC step from target minus slew.
// - Constant time step computed once per load.
// - Step count is two to code+6.
// - Device clears trigger after step recompute.
// - Mute ignores constant time locations.
// - Reset: linear rate five, values 1.0.
// - Ten safeload slots, two banks.
// - Safeload completes within one frame.
// - Only freshly written slots are sent.
// - Each slew advances once per frame.
// - Target initiate self-clears when done.
// - Mute zeroes targets; done flag read-clears.
`timescale 1ns/1ns
`include "slew_defs.svh"
module slew_ramp_safeload_engine
    import slew_pkg::*;
#(
    parameter int LOCS = `SLEW_LOCS,
    parameter int SLOTS = `SLOTS
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Frame strobe and control.
    input wire logic frame_i,
    input wire logic mute_i,
    input wire logic mute_done_rd_i,
    output logic mute_done_o,
    // Safeload slot writes.
    input wire logic slot_wr_i,
    input wire logic slot_bank_i,
    input wire logic [2:0] slot_idx_i,
    input wire logic [9:0] slot_addr_i,
    input wire logic [33:0] slot_data_i,
    input wire logic init_param_i,
    input wire logic init_target_i,
    output logic init_param_o,
    output logic init_target_o,
    // Parameter memory write port.
    output logic pram_we_o,
    output logic [9:0] pram_addr_o,
    output logic [27:0] pram_data_o,
    // Slew read port.
    input wire logic [5:0] slew_rd_addr_i,
    output logic [27:0] slew_rd_data_o
);
    // ------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------
    function automatic logic [27:0] lin_step(input logic [3:0] rate);
        // Each code scales the step by a tenth of a decade; code five is the unit step.
        case (rate)
            4'h0: lin_step = 28'h0006531;
            4'h1: lin_step = 28'h0005061;
            4'h2: lin_step = 28'h0003fd9;
            4'h3: lin_step = 28'h00032b7;
            4'h4: lin_step = 28'h0002849;
            4'h5: lin_step = `LIN_STEP_UNIT;
            4'h6: lin_step = 28'h000196b;
            4'h7: lin_step = 28'h0001431;
            4'h8: lin_step = 28'h000100a;
            4'h9: lin_step = 28'h0000cbd;
            4'ha: lin_step = 28'h0000a1f;
            4'hb: lin_step = 28'h000080a;
            4'hc: lin_step = 28'h0000663;
            4'hd: lin_step = 28'h0000512;
            4'he: lin_step = 28'h0000407;
            default: lin_step = 28'h0000333;
        endcase
    endfunction
    function automatic logic signed [27:0] mag28(input logic signed [27:0] x);
        mag28 = (x < 0) ? -x : x;
    endfunction
    function automatic logic signed [27:0] limit(input logic signed [27:0] cur, input logic signed [27:0] tgt,
                                                   input logic signed [27:0] stp);
        logic signed [28:0] nxt;
        nxt = 29'(cur) + 29'(stp);
        if ((stp >= 0 && nxt >= 29'(tgt)) || (stp < 0 && nxt <= 29'(tgt)))
            limit = tgt;
        else
            limit = nxt[27:0];
    endfunction
    // ------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------
    logic [33:0] target [LOCS];
    logic [27:0] slew [LOCS];
    logic [27:0] ct_step [LOCS];
    slot_s pslot [SLOTS];
    slot_s tslot [SLOTS];
    state_e state;
    state_e next_state;
    logic [5:0] loc;
    logic [5:0] next_loc;
    logic [2:0] sidx;
    logic [2:0] next_sidx;
    logic pend_p, pend_t, next_pend_p, next_pend_t;
    logic muted_all, next_mute_done, mute_done;
    // ------------------------------------------------------------
    // Per-location step computation.
    // ------------------------------------------------------------
    logic [33:0] tw;
    logic signed [27:0] cur, tgt, diff, mag, stp, newv, ct_new;
    logic [27:0] ct_tgt;
    logic [4:0] shamt;
    always_comb begin
        tw = target[loc];
        cur = slew[loc];
        tgt = tw[27:0];
        shamt = 5'(tw[`RATE_MSB:`RATE_LSB]) + 5'd4;
        ct_tgt = {{12{tw[`CT_DATA_MSB]}}, tw[`CT_DATA_MSB:`CT_DATA_LSB]} <<< 9;
        if (mute_i && tw[`SHAPE_MSB:`SHAPE_LSB] != SHAPE_CONST_TIME)
            tgt = '0;
        else if (tw[`SHAPE_MSB:`SHAPE_LSB] == SHAPE_CONST_TIME)
            tgt = ct_tgt;
        diff = 28'(tgt - cur);
        ct_new = mag28(diff) >>> (5'(tw[`CT_CNT_MSB:`CT_CNT_LSB]) + 5'(`STEP_CNT_BIAS));
        mag = '0;
        case (shape_e'(tw[`SHAPE_MSB:`SHAPE_LSB]))
            SHAPE_LINEAR: mag = lin_step(tw[`RATE_MSB:`RATE_LSB]);
            SHAPE_CONST_DB: mag = mag28(cur) >>> shamt;
            SHAPE_RC: mag = mag28(diff) >>> shamt;
            SHAPE_CONST_TIME: mag = tw[`CT_TRIG_BIT] ? ct_new : ct_step[loc];
            default: mag = '0;
        endcase
        if (mag == 0)
            mag = 28'sd1;
        stp = (diff < 0) ? -mag : mag;
        newv = (diff == 0) ? cur : limit(cur, tgt, stp);
    end
    // ------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_loc = loc;
        next_sidx = sidx;
        next_pend_p = pend_p | init_param_i;
        next_pend_t = pend_t | init_target_i;
        next_mute_done = mute_done_rd_i ? 1'b0 : mute_done;
        case (state)
            ST_IDLE: begin
                if (frame_i) begin
                    next_sidx = '0;
                    next_state = (pend_p || pend_t) ? ST_SAFELOAD : ST_SWEEP;
                end
            end
            ST_SAFELOAD: begin
                next_sidx = 3'(sidx + 3'd1);
                if (sidx == 3'(SLOTS - 1)) begin
                    next_pend_p = init_param_i;
                    next_pend_t = init_target_i;
                    next_loc = '0;
                    next_state = ST_SWEEP;
                end
            end
            ST_SWEEP: begin
                next_loc = 6'(loc + 6'd1);
                if (loc == 6'(LOCS - 1)) begin
                    next_state = ST_IDLE;
                    if (mute_i && muted_all)
                        next_mute_done = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end
    logic all_zero_run;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            loc <= '0;
            sidx <= '0;
            pend_p <= 1'b0;
            pend_t <= 1'b0;
            mute_done <= 1'b0;
        end else begin
            state <= next_state;
            loc <= next_loc;
            sidx <= next_sidx;
            pend_p <= next_pend_p;
            pend_t <= next_pend_t;
            mute_done <= next_mute_done;
        end
    end
    // Tracks whether every non constant time slew reached zero this sweep.
    always_ff @(posedge clk_i) begin
        if (srst_i)
            all_zero_run <= 1'b1;
        else if (state == ST_IDLE)
            all_zero_run <= 1'b1;
        else if (state == ST_SWEEP && tw[`SHAPE_MSB:`SHAPE_LSB] != SHAPE_CONST_TIME && newv != 0)
            all_zero_run <= 1'b0;
    end
    assign muted_all = all_zero_run && !(tw[`SHAPE_MSB:`SHAPE_LSB] != SHAPE_CONST_TIME && newv != 0);
    // ------------------------------------------------------------
    // Memories and slots.
    // ------------------------------------------------------------
    logic do_p, do_t;
    assign do_p = state == ST_SAFELOAD && pend_p && pslot[sidx].valid;
    assign do_t = state == ST_SAFELOAD && pend_t && tslot[sidx].valid;
    always_ff @(posedge clk_i) begin
        pram_we_o <= 1'b0;
        if (srst_i) begin
            pram_addr_o <= '0;
            pram_data_o <= '0;
            for (int i = 0; i < LOCS; i++) begin
                target[i] <= {SHAPE_LINEAR, `RESET_RATE, `ONE_523};
                slew[i] <= `ONE_523;
                ct_step[i] <= '0;
            end
            for (int s = 0; s < SLOTS; s++) begin
                pslot[s] <= '0;
                tslot[s] <= '0;
            end
        end else begin
            if (slot_wr_i && 32'(slot_idx_i) < SLOTS) begin
                if (slot_bank_i)
                    tslot[slot_idx_i] <= '{valid: 1'b1, addr: slot_addr_i, data: slot_data_i};
                else
                    pslot[slot_idx_i] <= '{valid: 1'b1, addr: slot_addr_i, data: slot_data_i};
            end
            if (do_p) begin
                pram_we_o <= 1'b1;
                pram_addr_o <= pslot[sidx].addr;
                pram_data_o <= pslot[sidx].data[27:0];
            end
            if (state == ST_SAFELOAD && pend_p && !(slot_wr_i && !slot_bank_i && slot_idx_i == sidx))
                pslot[sidx].valid <= 1'b0;
            if (state == ST_SAFELOAD && pend_t && !(slot_wr_i && slot_bank_i && slot_idx_i == sidx))
                tslot[sidx].valid <= 1'b0;
            if (do_t)
                target[tslot[sidx].addr[5:0]] <= tslot[sidx].data;
            if (state == ST_SWEEP) begin
                slew[loc] <= newv;
                if (tw[`SHAPE_MSB:`SHAPE_LSB] == SHAPE_CONST_TIME && tw[`CT_TRIG_BIT]) begin
                    ct_step[loc] <= ct_new;
                    target[loc][`CT_TRIG_BIT] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk_i) begin
        slew_rd_data_o <= slew[slew_rd_addr_i];
    end
    assign mute_done_o = mute_done;
    assign init_param_o = pend_p;
    assign init_target_o = pend_t;
endmodule // slew_ramp_safeload_engine

// ==== test/slew_engine_props.sv ====
`timescale 1ns/1ns
`include "slew_defs.svh"
module slew_engine_checker (
    // Observed ports.
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic frame_i,
    input wire logic mute_i,
    input wire logic mute_done_rd_i,
    input wire logic mute_done_o,
    input wire logic init_param_i,
    input wire logic init_param_o,
    input wire logic pram_we_o,
    input wire logic [27:0] slew_rd_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_pass_start;
        init_param_o && frame_i;
    endsequence
    sequence s_burst;
        pram_we_o [*5];
    endsequence
    property p_req_held;
        init_param_i |=> init_param_o;
    endproperty
    a_req_held: assert property (p_req_held) else $error("initiate not held");
    property p_done_bound;
        s_pass_start |-> ##[1:8] !init_param_o;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("safeload late");
    property p_we_needs_req;
        pram_we_o |-> $past(init_param_o, 2);
    endproperty
    a_we_needs_req: assert property (p_we_needs_req) else $error("write without request");
    property p_we_burst;
        s_burst |=> !pram_we_o;
    endproperty
    a_we_burst: assert property (p_we_burst) else $error("more than five writes");
    property p_mute_set;
        $rose(mute_done_o) |-> $past(mute_i);
    endproperty
    a_mute_set: assert property (p_mute_set) else $error("done without mute");
    property p_mute_hold;
        mute_done_o && !mute_done_rd_i |=> mute_done_o;
    endproperty
    a_mute_hold: assert property (p_mute_hold) else $error("done flag lost");
    property p_mute_clr;
        mute_done_rd_i && !mute_i |=> !mute_done_o;
    endproperty
    a_mute_clr: assert property (p_mute_clr) else $error("done flag not cleared");
    property p_reset_slew;
        $fell(srst_i) |=> slew_rd_data_o == `ONE_523;
    endproperty
    a_reset_slew: assert property (p_reset_slew) else $error("slew reset value");
endmodule // slew_engine_checker

// ==== test/host_model.sv ====
`timescale 1ns/1ns
module host_model (
    // Clock.
    input wire logic clk_i,
    // Slot and initiate requests.
    output logic slot_wr_o = 1'b0,
    output logic slot_bank_o = 1'b0,
    output logic [2:0] slot_idx_o = 3'h0,
    output logic [9:0] slot_addr_o = 10'h000,
    output logic [33:0] slot_data_o = 34'h000000000,
    output logic init_param_o = 1'b0,
    output logic init_target_o = 1'b0
);
    function automatic logic [33:0] ct_word(input logic [2:0] cnt, input logic [15:0] d);
        return {2'b11, 1'b1, cnt, d, 12'h000};
    endfunction
    task automatic put(input logic b, input logic [2:0] i, input logic [9:0] a, input logic [33:0] d);
        @(posedge clk_i);
        slot_wr_o <= 1'b1;
        slot_bank_o <= b;
        slot_idx_o <= i;
        slot_addr_o <= a;
        slot_data_o <= d;
        @(posedge clk_i);
        slot_wr_o <= 1'b0;
        slot_addr_o <= ~a;
        slot_data_o <= ~d;
    endtask
    task automatic go(input logic b);
        @(posedge clk_i);
        init_param_o <= !b;
        init_target_o <= b;
        @(posedge clk_i);
        init_param_o <= 1'b0;
        init_target_o <= 1'b0;
    endtask
endmodule // host_model

// ==== test/slew_ramp_safeload_engine_tb_top.sv ====
`timescale 1ns/1ns
module slew_ramp_safeload_engine_tb_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic frame_i = 1'b0;
    logic mute_i = 1'b0;
    logic mute_done_rd_i = 1'b0;
    logic [5:0] slew_rd_addr_i = 6'h00;
    logic wr, bank, ip, it, mute_done_o, init_param_o, init_target_o, pram_we_o;
    logic [2:0] idx;
    logic [9:0] addr, pram_addr_o;
    logic [33:0] data;
    logic [27:0] pram_data_o, slew_rd_data_o, v;
    logic [37:0] wq[$];
    int mismatches = 0;
    int samples_checked = 0;
    int i;
    always #4 clk_i = ~clk_i;
    host_model host (.clk_i(clk_i), .slot_wr_o(wr), .slot_bank_o(bank), .slot_idx_o(idx),
        .slot_addr_o(addr), .slot_data_o(data), .init_param_o(ip), .init_target_o(it));
    slew_ramp_safeload_engine uut (.clk_i(clk_i), .srst_i(srst_i), .frame_i(frame_i), .mute_i(mute_i),
        .mute_done_rd_i(mute_done_rd_i), .mute_done_o(mute_done_o), .slot_wr_i(wr), .slot_bank_i(bank),
        .slot_idx_i(idx), .slot_addr_i(addr), .slot_data_i(data), .init_param_i(ip), .init_target_i(it),
        .init_param_o(init_param_o), .init_target_o(init_target_o), .pram_we_o(pram_we_o),
        .pram_addr_o(pram_addr_o), .pram_data_o(pram_data_o), .slew_rd_addr_i(slew_rd_addr_i),
        .slew_rd_data_o(slew_rd_data_o));
    always @(posedge clk_i) if (pram_we_o === 1'b1) wq.push_back({pram_addr_o, pram_data_o});
    task automatic cmp(input logic [37:0] got, input logic [37:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input int n);
        repeat (n) begin
            frame_i <= 1'b1;
            @(posedge clk_i);
            frame_i <= 1'b0;
            repeat (71) @(posedge clk_i);
        end
    endtask
    task automatic slew(input logic [5:0] a);
        slew_rd_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1 v = slew_rd_data_o;
        @(posedge clk_i);
    endtask
    task automatic stop_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_param();
        host.put(1'b0, 3'h1, 10'h155, 34'h00abcdef);
        host.put(1'b0, 3'h3, 10'h2aa, 34'h01234567);
        host.go(1'b0);
        #1 cmp(init_param_o, 1'b1);
        @(posedge clk_i);
        wq.delete();
        frame(1);
        cmp(wq.size(), 2);
        cmp(wq[0], {10'h155, 28'h0abcdef});
        cmp(wq[1], {10'h2aa, 28'h1234567});
        cmp(init_param_o, 1'b0);
        host.go(1'b0);
        frame(1);
        cmp(wq.size(), 2);
        for (i = 0; i < 5; i++) host.put(1'b0, 3'(i), 10'(i + 8), 34'(i + 16));
        host.go(1'b0);
        frame(1);
        cmp(wq.size(), 7);
        for (i = 0; i < 5; i++) cmp(wq[i + 2], {10'(i + 8), 28'(i + 16)});
    endtask
    task automatic t_curves();
        host.put(1'b1, 3'h0, 10'h004, 34'h100000000);
        host.put(1'b1, 3'h1, 10'h005, 34'h200400000);
        host.go(1'b1);
        frame(1);
        slew(6'h04);
        cmp(v, 28'h0780000);
        slew(6'h05);
        cmp(v, 28'h07c0000);
        frame(1);
        slew(6'h04);
        cmp(v, 28'h0708000);
        slew(6'h05);
        cmp(v, 28'h0784000);
    endtask
    task automatic t_mute_ct();
        host.put(1'b1, 3'h0, 10'h002, host.ct_word(3'h0, 16'h2000));
        host.go(1'b1);
        #1 cmp(init_target_o, 1'b1);
        @(posedge clk_i);
        mute_i <= 1'b1;
        frame(1);
        cmp(init_target_o, 1'b0);
        slew(6'h00);
        cmp(v, 28'h07fe000);
        slew(6'h02);
        cmp(v, 28'h07f0000);
        frame(62);
        slew(6'h02);
        cmp(v !== 28'h0400000, 1'b1);
        frame(1);
        slew(6'h02);
        cmp(v, 28'h0400000);
        for (i = 0; i < 1100 && mute_done_o !== 1'b1; i++) frame(1);
        cmp(mute_done_o, 1'b1);
        slew(6'h00);
        cmp(v, 28'h0000000);
        slew(6'h02);
        cmp(v, 28'h0400000);
        mute_done_rd_i <= 1'b1;
        @(posedge clk_i);
        mute_done_rd_i <= 1'b0;
        mute_i <= 1'b0;
        @(posedge clk_i);
        #1 cmp(mute_done_o, 1'b0);
        @(posedge clk_i);
        mute_done_rd_i <= 1'b1;
        @(posedge clk_i);
        mute_done_rd_i <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        slew(6'h3f);
        cmp(v, 28'h0800000);
        t_param();
        t_curves();
        t_mute_ct();
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end
endmodule // slew_ramp_safeload_engine_tb_top
bind slew_ramp_safeload_engine slew_engine_checker chk (.clk_i(clk_i), .srst_i(srst_i), .frame_i(frame_i),
    .mute_i(mute_i), .mute_done_rd_i(mute_done_rd_i), .mute_done_o(mute_done_o), .init_param_i(init_param_i),
    .init_param_o(init_param_o), .pram_we_o(pram_we_o), .slew_rd_data_o(slew_rd_data_o));
